// ---- core/tx_frame_pkg.sv ----
package tx_frame_pkg;

    // Register offsets (bus address equals the printed offset)
    localparam logic [7:0] ADDR_BURST_LENGTH    = 8'h30;
    localparam logic [7:0] ADDR_TX_WAIT_CONTROL = 8'h31;
    localparam logic [7:0] ADDR_TX_WAIT_LOW     = 8'h32;
    localparam logic [7:0] ADDR_FRAME_CONTROL   = 8'h33;
    localparam logic [7:0] ADDR_RX_START_DETECT = 8'h34;
    localparam logic [7:0] ADDR_BURST_LEVEL     = 8'h3f;

    // Writable bit masks; the other bits are reserved
    localparam logic [7:0] MASK_BURST_LENGTH = 8'h77;
    localparam logic [7:0] MASK_FRAME_CONTROL = 8'hcf;

    // Reset values
    localparam logic [7:0] RST_BURST_LENGTH    = 8'h00;
    localparam logic [7:0] RST_TX_WAIT_CONTROL = 8'hc0;
    localparam logic [7:0] RST_TX_WAIT_LOW     = 8'h00;
    localparam logic [7:0] RST_FRAME_CONTROL   = 8'h00;

    // Field positions
    localparam int SECOND_BURST_LSB   = 4;
    localparam int FIRST_BURST_LSB    = 0;
    localparam int WAIT_ORIGIN_BIT    = 7;
    localparam int WAIT_UNIT_BIT      = 6;
    localparam int WAIT_UPPER_LSB     = 3;
    localparam int STOP_GUARD_LSB     = 0;
    localparam int TX_PARITY_BIT      = 7;
    localparam int RX_PARITY_BIT      = 6;
    localparam int STOP_SYMBOL_LSB    = 2;
    localparam int START_SYMBOL_LSB   = 0;
    localparam int SOF_IRQ_EN_BIT     = 5;
    localparam int SOF_SEEN_BIT       = 4;
    localparam int SUBC_IRQ_EN_BIT    = 2;
    localparam int SUBC_SEEN_BIT      = 1;

    // Timing: wait unit of 16 carrier periods at 13.56 MHz
    localparam int CLK_KHZ          = 100000;
    localparam int CARRIER_KHZ      = 13560;
    localparam int CARRIER_PERIODS  = 16;
    localparam int CARRIER16_CYCLES =
        (CARRIER_PERIODS * CLK_KHZ + CARRIER_KHZ - 1) / CARRIER_KHZ;

    typedef enum logic [3:0] {
        KIND_DATA    = 4'h0,
        KIND_PARITY  = 4'h1,
        KIND_SYMBOL0 = 4'h2,
        KIND_SYMBOL1 = 4'h3,
        KIND_SYMBOL2 = 4'h4,
        KIND_STOPBIT = 4'h5,
        KIND_GUARD   = 4'h6
    } sym_kind_t;

    // Burst bit count for a 3-bit length code
    function automatic logic [8:0] burst_bits(input logic [2:0] code);
        case (code)
            3'h0:    burst_bits = 9'h008;
            3'h1:    burst_bits = 9'h010;
            3'h2:    burst_bits = 9'h020;
            3'h3:    burst_bits = 9'h030;
            3'h4:    burst_bits = 9'h040;
            3'h5:    burst_bits = 9'h060;
            3'h6:    burst_bits = 9'h080;
            default: burst_bits = 9'h100;
        endcase
    endfunction

endpackage

// ---- core/byte_buffer.sv ----
`timescale 1ns/1ps
`default_nettype none
module byte_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input  wire logic             core_clk_in,
    input  wire logic             srst_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
    } buf_state_t;

    buf_state_t q;
    buf_state_t next_q;
    logic       push;
    logic       pop;

    assign in_ready_out  = (q.count != CW'(DEPTH));
    assign out_valid_out = (q.count != '0);
    assign out_data_out  = q.mem[q.rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_valid_out && out_ready_in;

    always_comb begin
        next_q = q;
        if (push) begin
            next_q.mem[q.wr_ptr] = in_data_in;
            next_q.wr_ptr = (q.wr_ptr == PW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_q.rd_ptr = (q.rd_ptr == PW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
        end
        next_q.count = q.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule // byte_buffer
`default_nettype wire

// ---- core/contactless_tx_frame_timing.sv ----
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Second symbol burst code picks 8..256 bits
// - First symbol burst code, same encoding
// - Burst is unmodulated at selected level
// - Wait origin: end of transmit or receive
// - Wait unit: 16 carrier periods or half-bit
// - Eleven-bit wait count, upper bits 5:3
// - Programmed wait, once loaded at its origin, holds off the next transmission
// - Stop field: stop-bit plus guard units
// - Transmit parity appended after each byte
// - Receive parity checked, never stored
// - Stop symbol selection
// - Start symbol selection
// - Frame-start detect raises enabled interrupt
// - Sticky frame-start flag until cleared
// - Subcarrier detect raises same interrupt
// - Sticky subcarrier flag until cleared
// - Live subcarrier status, unlatched
// - Wait control resets to 0xc0
module contactless_tx_frame_timing #(
    parameter int BITSTREAM_KHZ = 106
) (
    input  wire logic       core_clk_in,
    input  wire logic       srst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    output logic [7:0]      reg_rdata_out,
    input  wire logic [7:0] tx_byte_in,
    input  wire logic       tx_last_in,
    input  wire logic       tx_valid_in,
    output logic            tx_ready_out,
    output logic            tx_bit_out,
    output logic [3:0]      tx_kind_out,
    output logic            tx_sym_valid_out,
    input  wire logic       tx_sym_ready_in,
    input  wire logic       rx_end_in,
    input  wire logic [7:0] rx_byte_in,
    input  wire logic       rx_parity_in,
    input  wire logic       rx_byte_valid_in,
    output logic [7:0]      rx_fifo_data_out,
    output logic            rx_fifo_write_out,
    output logic            rx_parity_error_out,
    input  wire logic       rx_sof_in,
    input  wire logic       subcarrier_live_in,
    output logic            receive_frame_start_irq_out
);
    localparam int HALF_ETU_CYCLES =
        (tx_frame_pkg::CLK_KHZ + 2 * BITSTREAM_KHZ - 1) / (2 * BITSTREAM_KHZ);
    localparam logic [15:0] UNIT_CARRIER =
        16'(tx_frame_pkg::CARRIER16_CYCLES - 1);
    localparam logic [15:0] UNIT_HALF_ETU = 16'(HALF_ETU_CYCLES - 1);

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_START  = 4'h1,
        ST_DATA   = 4'h2,
        ST_PARITY = 4'h3,
        ST_GUARD  = 4'h4,
        ST_NEXT   = 4'h5,
        ST_STOP   = 4'h6,
        ST_END    = 4'h7
    } tx_state_t;

    typedef struct packed {
        logic [7:0]  burst_length;
        logic [7:0]  tx_wait_control;
        logic [7:0]  tx_wait_low;
        logic [7:0]  frame_control;
        logic        sof_irq_en;
        logic        sof_seen;
        logic        subcarrier_irq_en;
        logic        subcarrier_seen;
        logic        burst_level_control;
        logic [7:0]  rdata;
        tx_state_t   state;
        logic [8:0]  sym_cnt;
        logic [7:0]  shreg;
        logic        last;
        logic [10:0] wait_left;
        logic [15:0] unit_cnt;
        logic        sym_valid;
        logic        sym_bit;
        logic [3:0]  sym_kind;
        logic        subc_prev;
        logic        irq;
        logic [7:0]  rx_data;
        logic        rx_we;
        logic        rx_perr;
    } frame_state_t;

    frame_state_t q;
    frame_state_t next_q;

    logic [8:0]  buf_out;
    logic        buf_valid;
    logic        buf_pop;
    logic        adv;
    logic [2:0]  stop_guard_length;
    logic [1:0]  start_sel;
    logic [1:0]  stop_sel;
    logic [10:0] guard_wait_count;
    logic        transmit_parity_enable;
    logic        receive_parity_enable;
    logic [8:0]  first_len;
    logic [8:0]  second_len;

    byte_buffer #(
        .WIDTH (9),
        .DEPTH (2)
    ) u_buf (
        .core_clk_in   (core_clk_in),
        .srst_in       (srst_in),
        .in_data_in    ({tx_last_in, tx_byte_in}),
        .in_valid_in   (tx_valid_in),
        .in_ready_out  (tx_ready_out),
        .out_data_out  (buf_out),
        .out_valid_out (buf_valid),
        .out_ready_in  (buf_pop)
    );

    assign stop_guard_length = q.tx_wait_control[2:0];
    assign guard_wait_count  = {q.tx_wait_control[5:3], q.tx_wait_low};
    assign start_sel = q.frame_control[tx_frame_pkg::START_SYMBOL_LSB +: 2];
    assign stop_sel  = q.frame_control[tx_frame_pkg::STOP_SYMBOL_LSB +: 2];
    assign transmit_parity_enable =
        q.frame_control[tx_frame_pkg::TX_PARITY_BIT];
    assign receive_parity_enable =
        q.frame_control[tx_frame_pkg::RX_PARITY_BIT];
    assign first_len = tx_frame_pkg::burst_bits(
        q.burst_length[tx_frame_pkg::FIRST_BURST_LSB +: 3]);
    assign second_len = tx_frame_pkg::burst_bits(
        q.burst_length[tx_frame_pkg::SECOND_BURST_LSB +: 3]);
    // A new symbol may be loaded once the current one has been taken
    assign adv = !q.sym_valid || tx_sym_ready_in;
    assign buf_pop = adv && buf_valid &&
        ((q.state == ST_IDLE && q.wait_left == '0) ||
         (q.state == ST_NEXT && !q.last));

    assign tx_bit_out       = q.sym_bit;
    assign tx_kind_out      = q.sym_kind;
    assign tx_sym_valid_out = q.sym_valid;
    assign reg_rdata_out    = q.rdata;
    assign rx_fifo_data_out = q.rx_data;
    assign rx_fifo_write_out = q.rx_we;
    assign rx_parity_error_out = q.rx_perr;
    assign receive_frame_start_irq_out = q.irq;

    always_comb begin
        logic [1:0] sel;
        logic [8:0] len;
        logic       to_next;
        sel = (q.state == ST_STOP) ? stop_sel : start_sel;
        len = (sel == 2'h1) ? first_len : second_len;
        to_next = 1'b0;
        next_q = q;
        next_q.rdata = 8'h00;
        next_q.rx_we = 1'b0;
        next_q.irq = 1'b0;
        next_q.subc_prev = subcarrier_live_in;
        if (adv) begin
            next_q.sym_valid = 1'b0;
        end

        // Register writes
        if (reg_write_in) begin
            case (reg_addr_in)
                tx_frame_pkg::ADDR_BURST_LENGTH:
                    next_q.burst_length =
                        reg_wdata_in & tx_frame_pkg::MASK_BURST_LENGTH;
                tx_frame_pkg::ADDR_TX_WAIT_CONTROL:
                    next_q.tx_wait_control = reg_wdata_in;
                tx_frame_pkg::ADDR_TX_WAIT_LOW:
                    next_q.tx_wait_low = reg_wdata_in;
                tx_frame_pkg::ADDR_FRAME_CONTROL:
                    next_q.frame_control =
                        reg_wdata_in & tx_frame_pkg::MASK_FRAME_CONTROL;
                tx_frame_pkg::ADDR_RX_START_DETECT: begin
                    next_q.sof_irq_en =
                        reg_wdata_in[tx_frame_pkg::SOF_IRQ_EN_BIT];
                    next_q.subcarrier_irq_en =
                        reg_wdata_in[tx_frame_pkg::SUBC_IRQ_EN_BIT];
                    // Writing zero clears a sticky flag; one leaves it
                    if (!reg_wdata_in[tx_frame_pkg::SOF_SEEN_BIT]) begin
                        next_q.sof_seen = 1'b0;
                    end
                    if (!reg_wdata_in[tx_frame_pkg::SUBC_SEEN_BIT]) begin
                        next_q.subcarrier_seen = 1'b0;
                    end
                end
                tx_frame_pkg::ADDR_BURST_LEVEL:
                    next_q.burst_level_control = reg_wdata_in[0];
                default: ;
            endcase
        end

        // Register reads; unmapped addresses return zero
        if (reg_read_in) begin
            case (reg_addr_in)
                tx_frame_pkg::ADDR_BURST_LENGTH:
                    next_q.rdata = q.burst_length;
                tx_frame_pkg::ADDR_TX_WAIT_CONTROL:
                    next_q.rdata = q.tx_wait_control;
                tx_frame_pkg::ADDR_TX_WAIT_LOW:
                    next_q.rdata = q.tx_wait_low;
                tx_frame_pkg::ADDR_FRAME_CONTROL:
                    next_q.rdata = q.frame_control;
                tx_frame_pkg::ADDR_RX_START_DETECT:
                    next_q.rdata = {2'b00, q.sof_irq_en, q.sof_seen, 1'b0,
                        q.subcarrier_irq_en, q.subcarrier_seen,
                        subcarrier_live_in};
                tx_frame_pkg::ADDR_BURST_LEVEL:
                    next_q.rdata = {7'h00, q.burst_level_control};
                default:
                    next_q.rdata = 8'h00;
            endcase
        end

        // Detection events; set beats a clear written in the same cycle
        if (rx_sof_in) begin
            next_q.sof_seen = 1'b1;
        end
        if (subcarrier_live_in) begin
            next_q.subcarrier_seen = 1'b1;
        end
        next_q.irq = (rx_sof_in && q.sof_irq_en) ||
            (subcarrier_live_in && !q.subc_prev &&
             q.subcarrier_irq_en);

        // Receive parity: parity is checked, only the byte goes onward
        if (rx_byte_valid_in) begin
            next_q.rx_we = 1'b1;
            next_q.rx_data = rx_byte_in;
            next_q.rx_perr = receive_parity_enable &&
                ((^rx_byte_in) == rx_parity_in);
        end

        // Guard wait countdown in the selected unit
        if (q.wait_left != '0) begin
            if (q.unit_cnt == '0) begin
                next_q.wait_left = q.wait_left - 11'h001;
                next_q.unit_cnt = q.tx_wait_control[tx_frame_pkg::WAIT_UNIT_BIT]
                    ? UNIT_HALF_ETU : UNIT_CARRIER;
            end else begin
                next_q.unit_cnt = q.unit_cnt - 16'h0001;
            end
        end
        if (rx_end_in &&
            q.tx_wait_control[tx_frame_pkg::WAIT_ORIGIN_BIT]) begin
            next_q.wait_left = guard_wait_count;
            next_q.unit_cnt = q.tx_wait_control[tx_frame_pkg::WAIT_UNIT_BIT]
                ? UNIT_HALF_ETU : UNIT_CARRIER;
        end

        // Transmit sequencer
        case (q.state)
            ST_IDLE: begin
                if (buf_pop) begin
                    next_q.shreg = buf_out[7:0];
                    next_q.last = buf_out[8];
                    next_q.sym_cnt = '0;
                    next_q.state = (start_sel != 2'h0) ? ST_START : ST_DATA;
                end
            end
            ST_START, ST_STOP: begin
                if (adv) begin
                    next_q.sym_valid = 1'b1;
                    next_q.sym_bit = q.burst_level_control;
                    next_q.sym_cnt = q.sym_cnt + 9'h001;
                    case (sel)
                        2'h1: next_q.sym_kind = tx_frame_pkg::KIND_SYMBOL0;
                        2'h2: next_q.sym_kind = tx_frame_pkg::KIND_SYMBOL1;
                        default: next_q.sym_kind = tx_frame_pkg::KIND_SYMBOL2;
                    endcase
                    if (sel == 2'h3 || q.sym_cnt == len - 9'h001) begin
                        next_q.sym_cnt = '0;
                        next_q.state = (q.state == ST_START) ? ST_DATA : ST_END;
                    end
                end
            end
            ST_DATA: begin
                if (adv) begin
                    next_q.sym_valid = 1'b1;
                    next_q.sym_kind = tx_frame_pkg::KIND_DATA;
                    next_q.sym_bit = q.shreg[q.sym_cnt[2:0]];
                    next_q.sym_cnt = q.sym_cnt + 9'h001;
                    if (q.sym_cnt == 9'h007) begin
                        next_q.sym_cnt = '0;
                        if (transmit_parity_enable) begin
                            next_q.state = ST_PARITY;
                        end else begin
                            to_next = 1'b1;
                        end
                    end
                end
            end
            ST_PARITY: begin
                if (adv) begin
                    next_q.sym_valid = 1'b1;
                    next_q.sym_kind = tx_frame_pkg::KIND_PARITY;
                    next_q.sym_bit = ~^q.shreg;
                    to_next = 1'b1;
                end
            end
            ST_GUARD: begin
                if (adv) begin
                    next_q.sym_valid = 1'b1;
                    next_q.sym_bit = 1'b1;
                    next_q.sym_kind = (q.sym_cnt == '0) ?
                        tx_frame_pkg::KIND_STOPBIT : tx_frame_pkg::KIND_GUARD;
                    next_q.sym_cnt = q.sym_cnt + 9'h001;
                    if (q.sym_cnt == {6'h00, stop_guard_length} - 9'h001) begin
                        next_q.sym_cnt = '0;
                        next_q.state = ST_NEXT;
                    end
                end
            end
            ST_NEXT: begin
                if (q.last) begin
                    next_q.state = (stop_sel != 2'h0) ? ST_STOP : ST_END;
                end else if (buf_pop) begin
                    next_q.shreg = buf_out[7:0];
                    next_q.last = buf_out[8];
                    next_q.state = ST_DATA;
                end
            end
            ST_END: begin
                // Frame ends when the final symbol has been taken
                if (adv) begin
                    next_q.state = ST_IDLE;
                    if (!q.tx_wait_control[tx_frame_pkg::WAIT_ORIGIN_BIT]) begin
                        next_q.wait_left = guard_wait_count;
                        next_q.unit_cnt =
                            q.tx_wait_control[tx_frame_pkg::WAIT_UNIT_BIT]
                            ? UNIT_HALF_ETU : UNIT_CARRIER;
                    end
                end
            end
            default: next_q.state = ST_IDLE;
        endcase
        if (to_next) begin
            next_q.state = (stop_guard_length != 3'h0) ? ST_GUARD : ST_NEXT;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.burst_length <= tx_frame_pkg::RST_BURST_LENGTH;
            q.tx_wait_control <= tx_frame_pkg::RST_TX_WAIT_CONTROL;
            q.tx_wait_low <= tx_frame_pkg::RST_TX_WAIT_LOW;
            q.frame_control <= tx_frame_pkg::RST_FRAME_CONTROL;
        end else begin
            q <= next_q;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    sequence s_byte_done;
        q.state == ST_DATA && adv && q.sym_cnt == 9'h007;
    endsequence

    AST_SECOND_BURST: assert property (
        q.state == ST_START && start_sel == 2'h2 && adv &&
        q.sym_cnt == second_len - 9'h001 |=> q.state == ST_DATA)
        else $error("second symbol burst length wrong");
    AST_FIRST_BURST: assert property (
        q.state == ST_STOP && stop_sel == 2'h1 && adv &&
        q.sym_cnt < first_len - 9'h001 |=> q.state == ST_STOP)
        else $error("first symbol burst ended early");
    AST_BURST_LEVEL: assert property (
        q.sym_valid && q.sym_kind == tx_frame_pkg::KIND_SYMBOL0
        |-> q.sym_bit == q.burst_level_control)
        else $error("burst level mismatch");
    AST_WAIT_LOAD: assert property (
        rx_end_in && q.tx_wait_control[7] |=> q.wait_left == $past(guard_wait_count))
        else $error("wait not loaded at end of reception");
    AST_WAIT_HOLD: assert property (
        q.state == ST_IDLE && next_q.state != ST_IDLE |-> q.wait_left == '0)
        else $error("transmission started inside wait");
    sequence s_parity_due;
        s_byte_done ##0 transmit_parity_enable;
    endsequence

    AST_PARITY_STEP: assert property (
        s_parity_due |=> q.state == ST_PARITY)
        else $error("parity symbol missing");
    AST_PARITY_BIT: assert property (
        q.state == ST_PARITY && adv |=>
        q.sym_valid && q.sym_kind == tx_frame_pkg::KIND_PARITY &&
        q.sym_bit == ~^q.shreg)
        else $error("parity bit wrong");
    AST_SOF_STICKY: assert property (
        rx_sof_in |=> q.sof_seen)
        else $error("frame start flag not set");
    AST_SOF_IRQ: assert property (
        rx_sof_in && q.sof_irq_en |=> receive_frame_start_irq_out)
        else $error("frame start interrupt missing");
endmodule // contactless_tx_frame_timing
`default_nettype wire

// ---- test/rf_symbol_sink.sv ----
`timescale 1ns/1ps
`default_nettype none
module rf_symbol_sink (
    input  wire logic core_clk_in,
    input  wire logic srst_in,
    input  wire logic stall_in,
    input  wire logic sym_valid_in,
    output logic      sym_ready_out
);
    // Slow mode accepts on alternate cycles so held symbols get exercised
    logic phase;
    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            phase <= 1'b0;
        end else begin
            phase <= ~phase;
        end
    end
    assign sym_ready_out = ~stall_in | phase;
endmodule // rf_symbol_sink
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [7:0] TX_DATA = 8'ha5;
    localparam int         WAIT_CYC = 259 * tx_frame_pkg::CARRIER16_CYCLES;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       wr_en = 1'b0, rd_en = 1'b0, txv = 1'b0, txl = 1'b1;
    logic       rxv = 1'b0, rxp = 1'b0, sof = 1'b0, live = 1'b0;
    logic       rx_end = 1'b0, stall = 1'b0;
    logic       txr, sbit, sv, srdy, fw, perr, irq;
    logic [7:0] addr = 8'h00, wd = 8'h00, txb = 8'h00, rxb = 8'h00;
    logic [7:0] rdata, fd;
    logic [3:0] kind;
    logic [3:0] kinds [40];
    logic       bits [40];
    int         stamp [40];
    int         nsym = 0, cyc = 0, num_errors = 0, check_count = 0;

    always #5 clk = ~clk;

    contactless_tx_frame_timing dut (.core_clk_in(clk), .srst_in(rst),
        .reg_addr_in(addr), .reg_wdata_in(wd), .reg_write_in(wr_en),
        .reg_read_in(rd_en), .reg_rdata_out(rdata), .tx_byte_in(txb),
        .tx_last_in(txl), .tx_valid_in(txv), .tx_ready_out(txr),
        .tx_bit_out(sbit), .tx_kind_out(kind), .tx_sym_valid_out(sv),
        .tx_sym_ready_in(srdy), .rx_end_in(rx_end), .rx_byte_in(rxb),
        .rx_parity_in(rxp), .rx_byte_valid_in(rxv), .rx_fifo_data_out(fd),
        .rx_fifo_write_out(fw), .rx_parity_error_out(perr),
        .rx_sof_in(sof), .subcarrier_live_in(live),
        .receive_frame_start_irq_out(irq));
    rf_symbol_sink sink (.core_clk_in(clk), .srst_in(rst), .stall_in(stall),
        .sym_valid_in(sv), .sym_ready_out(srdy));

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (!rst && sv && srdy && nsym < 40) begin
            kinds[nsym] <= kind;
            bits[nsym] <= sbit;
            stamp[nsym] <= cyc;
            nsym <= nsym + 1;
        end
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk("rdata", 32'(rdata), 32'(exp));
    endtask

    // The interrupt is a one-cycle pulse, so poll right after each edge
    task automatic wait_irq();
        int k;
        #1;
        for (k = 0; k < 4 && irq !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk("irq", 32'(irq), 32'h1);
    endtask

    task automatic rx(input logic [7:0] b, input logic p, e);
        @(posedge clk);
        rxb <= b;
        rxp <= p;
        rxv <= 1'b1;
        @(posedge clk);
        rxv <= 1'b0;
        #1 chk("fifo write", 32'(fw), 32'h1);
        chk("fifo data", 32'(fd), 32'(b));
        chk("parity error", 32'(perr), 32'(e));
    endtask

    task automatic send(input logic [7:0] b);
        logic r;
        @(posedge clk);
        txb <= b;
        txv <= 1'b1;
        r = 1'b0;
        for (int k = 0; k < 50 && !r; k++) begin
            @(negedge clk);
            r = txr;
            @(posedge clk);
        end
        txv <= 1'b0;
        chk("tx accepted", 32'(r), 32'h1);
    endtask

    task automatic wait_syms(input int n);
        for (int k = 0; k < 40000 && nsym < n; k++) @(posedge clk);
        if (nsym < n) begin
            chk("symbol count", nsym, n);
            stop_test();
        end
    endtask

    function automatic logic [4:0] exp_sym(input int i);
        if (i == 0) return {4'h4, 1'b0};
        if (i <= 8) return {4'h0, TX_DATA[i-1]};
        if (i == 9) return {4'h1, 1'b1};
        if (i == 10) return {4'h5, 1'b0};
        if (i == 11) return {4'h6, 1'b0};
        return {4'h2, 1'b1};
    endfunction

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(8'h31, 8'hc0);
        rd(8'h35, 8'h00);
        wr(8'h30, 8'hff);
        rd(8'h30, 8'h77);
        wr(8'h33, 8'hff);
        rd(8'h33, 8'hcf);
        wr(8'h34, 8'h24);
        @(posedge clk) sof <= 1'b1;
        @(posedge clk) sof <= 1'b0;
        wait_irq();
        rd(8'h34, 8'h34);
        wr(8'h34, 8'h24);
        rd(8'h34, 8'h24);
        @(posedge clk) live <= 1'b1;
        wait_irq();
        rd(8'h34, 8'h27);
        @(posedge clk) live <= 1'b0;
        rd(8'h34, 8'h26);
        wr(8'h33, 8'h40);
        rx(8'h01, 1'b1, 1'b1);
        rx(8'h01, 1'b0, 1'b0);
        wr(8'h33, 8'h87);
        wr(8'h30, 8'h00);
        wr(8'h3f, 8'h01);
        wr(8'h32, 8'h03);
        // Reset origin is end of reception: start a half-bit wait from rx
        @(posedge clk) rx_end <= 1'b1;
        @(posedge clk) rx_end <= 1'b0;
        wr(8'h31, 8'h0a);
        stall <= 1'b1;
        send(TX_DATA);
        wait_syms(20);
        stall <= 1'b0;
        send(TX_DATA);
        wait_syms(40);
        for (int i = 0; i < 40; i++) begin
            chk("kind", 32'(kinds[i]), 32'(exp_sym(i % 20) >> 1));
            if (i % 20 != 0 && i % 20 != 10 && i % 20 != 11)
                chk("bit", 32'(bits[i]), 32'(exp_sym(i % 20) & 1));
        end
        chk("wait", 32'(stamp[20] - stamp[19] >= WAIT_CYC &&
            stamp[20] - stamp[19] < WAIT_CYC + 20), 32'h1);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
